// file: include/iob_regs.svh
`ifndef IOB_REGS_SVH
`define IOB_REGS_SVH
`define IOB_DEV_W 7
`define IOB_DATA_W 36
`define IOB_DEV_DATA_W 36
`define IOB_CTL_W 18
`define IOB_CMD_W 3
`define IOB_CHANS 7
`define IOB_CHAN_LSB 0
`define IOB_CHAN_MSB 2
`define IOB_SVC_BIT 3
`define IOB_FIFO_DEPTH 32
`define IOB_REQ_W 46
`define IOB_REQ_CMD_LSB 43
`define IOB_REQ_DEV_LSB 36
`define IOB_CTL_RST 18'h00000
`define IOB_DATA_RST 36'h000000000
`endif

// file: include/iob_pkg.sv
`default_nettype none
`include "iob_regs.svh"
package iob_pkg;
    typedef enum logic [`IOB_CMD_W-1:0] {
        NO_CMD = 3'b000,
        CONTROL_LOAD_CMD = 3'b001,
        CONDITION_READ_CMD = 3'b010,
        DATA_READ_CMD = 3'b011,
        DATA_WRITE_CMD = 3'b100
    } iob_cmd_t;
    typedef enum logic [1:0] {
        HS_IDLE = 2'b00,
        HS_ISSUE = 2'b01,
        HS_WAIT = 2'b10
    } iob_host_state_t;
endpackage
`default_nettype wire

// file: include/iob_bus_if.sv
`timescale 1ns/100ps
`default_nettype none
`include "iob_regs.svh"
interface iob_bus_if;
    logic [`IOB_DEV_W-1:0] devNum;
    iob_pkg::iob_cmd_t cmd;
    logic cmdStrobe;
    logic [`IOB_DATA_W-1:0] hostData;
    logic hostDataOe_n;
    logic [`IOB_DATA_W-1:0] devData;
    logic devDataOe_n;
    logic [`IOB_DATA_W-1:0] busData;
    logic [`IOB_CHANS:1] irqReq;
    logic [`IOB_CHANS:1] chanActive;
    // Undriven data lines idle at zero.
    assign busData = !devDataOe_n ? devData :
                     (!hostDataOe_n ? hostData : '0);
    modport device (input devNum, cmd, cmdStrobe, busData, chanActive,
                    output devData, devDataOe_n, irqReq);
    modport host (input busData, irqReq,
                  output devNum, cmd, cmdStrobe, hostData, hostDataOe_n,
                  chanActive);
endinterface
`default_nettype wire

// file: verilog/iob_device.sv
`timescale 1ns/100ps
`default_nettype none
`include "iob_regs.svh"
module iob_device #(
    parameter logic [`IOB_DEV_W-1:0] DevNum = 7'h01,
    parameter logic [`IOB_DEV_W-1:0] StatNum = 7'h02,
    parameter bit HasSepStat = 1'b0
) (
    input wire logic mclk,
    input wire logic sys_rst,
    iob_bus_if.device bus,
    input wire logic [`IOB_CTL_W-1:0] userStatus,
    input wire logic userLoad,
    input wire logic [`IOB_DEV_DATA_W-1:0] userData,
    output logic [`IOB_CTL_W-1:0] ctrlOut,
    output logic [`IOB_DEV_DATA_W-1:0] dataOut,
    output logic ctrlLoadPulse,
    output logic dataWritePulse,
    output logic dataReadPulse
);
    typedef struct packed {
        logic [`IOB_CTL_W-1:0] ctrl;
        logic [`IOB_DEV_DATA_W-1:0] data;
        logic [`IOB_DATA_W-1:0] drv;
        logic drvOe_n;
        logic [`IOB_CHANS:1] irq;
        logic ldPulse;
        logic wrPulse;
        logic rdPulse;
    } iob_dev_state_t;

    iob_dev_state_t st_r;
    iob_dev_state_t st_nxt;
    logic [`IOB_CHANS:1] irq_nxt;
    logic hit;
    logic statHit;
    logic [`IOB_CHAN_MSB:`IOB_CHAN_LSB] chanSel;

    assign hit = bus.cmdStrobe && (bus.devNum == DevNum);
    assign statHit = HasSepStat && bus.cmdStrobe &&
                     (bus.devNum == StatNum);
    assign chanSel = st_r.ctrl[`IOB_CHAN_MSB:`IOB_CHAN_LSB];

    // Each channel line is requested only while that line is free.
    genvar k;
    generate
        for (k = 1; k <= `IOB_CHANS; k++) begin : gChan
            assign irq_nxt[k] = st_r.ctrl[`IOB_SVC_BIT] &&
                (chanSel == (`IOB_CHAN_MSB+1)'(k)) &&
                !bus.chanActive[k];
        end
    endgenerate

    always_comb begin
        st_nxt = st_r;
        st_nxt.drv = '0;
        st_nxt.drvOe_n = 1'b1;
        st_nxt.ldPulse = 1'b0;
        st_nxt.wrPulse = 1'b0;
        st_nxt.rdPulse = 1'b0;
        st_nxt.irq = irq_nxt;
        if (userLoad) begin
            st_nxt.data = userData;
        end
        if (hit) begin
            case (bus.cmd)
                iob_pkg::CONTROL_LOAD_CMD: begin
                    st_nxt.ctrl = bus.busData[`IOB_CTL_W-1:0];
                    st_nxt.ldPulse = 1'b1;
                end
                iob_pkg::CONDITION_READ_CMD: begin
                    // Without a separate status register both halves go.
                    if (HasSepStat) begin
                        st_nxt.drv = {{(`IOB_DATA_W-`IOB_CTL_W){1'b0}},
                                      st_r.ctrl};
                    end else begin
                        st_nxt.drv = {userStatus, st_r.ctrl};
                    end
                    st_nxt.drvOe_n = 1'b0;
                end
                iob_pkg::DATA_READ_CMD: begin
                    st_nxt.drv = `IOB_DATA_W'(st_r.data);
                    st_nxt.drvOe_n = 1'b0;
                    st_nxt.rdPulse = 1'b1;
                end
                iob_pkg::DATA_WRITE_CMD: begin
                    st_nxt.data =
                        bus.busData[`IOB_DEV_DATA_W-1:0];
                    st_nxt.wrPulse = 1'b1;
                end
                default: begin
                    st_nxt.drvOe_n = 1'b1;
                end
            endcase
        end else if (statHit &&
                     bus.cmd == iob_pkg::CONDITION_READ_CMD) begin
            st_nxt.drv = {{(`IOB_DATA_W-`IOB_CTL_W){1'b0}},
                          userStatus};
            st_nxt.drvOe_n = 1'b0;
        end
    end

    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            st_r.ctrl <= `IOB_CTL_RST;
            st_r.data <= `IOB_DATA_RST;
            st_r.drv <= '0;
            st_r.drvOe_n <= 1'b1;
            st_r.irq <= '0;
            st_r.ldPulse <= 1'b0;
            st_r.wrPulse <= 1'b0;
            st_r.rdPulse <= 1'b0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign bus.devData = st_r.drv;
    assign bus.devDataOe_n = st_r.drvOe_n;
    assign bus.irqReq = st_r.irq;
    assign ctrlOut = st_r.ctrl;
    assign dataOut = st_r.data;
    assign ctrlLoadPulse = st_r.ldPulse;
    assign dataWritePulse = st_r.wrPulse;
    assign dataReadPulse = st_r.rdPulse;
endmodule
`default_nettype wire

// file: verilog/iob_host.sv
// Functional notes
// - Up to 128 devices, 7-bit select number.
// - Device decodes number, answers only its own.
// - Transfer only with own number and command.
// - Four functions over data, control, status.
// - Data register sits on low data lines.
// - Control and status at most 18 bits.
// - Separate status reads at second number.
// - Control load writes control from data lines.
// - Condition read returns control and/or status.
// - Data read drives data register onto lines.
// - Data write loads data register from lines.
// - Seven interrupt lines, any devices per line.
// - Low three control bits pick channel.
// - Service bit and free channel raise request.
// - Processor grants lowest free uncommitted channel.
`timescale 1ns/100ps
`default_nettype none
`include "iob_regs.svh"
module iob_fifo #(
    parameter int Width = 8,
    parameter int Depth = 32
) (
    input wire logic mclk,
    input wire logic sys_rst,
    input wire logic inValid,
    output logic inReady,
    input wire logic [Width-1:0] inData,
    output logic outValid,
    input wire logic outReady,
    output logic [Width-1:0] outData
);
    localparam int AW = $clog2(Depth);
    typedef struct packed {
        logic [AW-1:0] wrPtr;
        logic [AW-1:0] rdPtr;
        logic [AW:0] count;
        logic full;
    } iob_fifo_state_t;

    iob_fifo_state_t st_r;
    iob_fifo_state_t st_nxt;
    logic [Width-1:0] mem [Depth];
    logic push;
    logic pop;

    assign inReady = !st_r.full;
    assign outValid = (st_r.count != '0);
    assign outData = mem[st_r.rdPtr];
    assign push = inValid && inReady;
    assign pop = outValid && outReady;

    always_comb begin
        st_nxt = st_r;
        if (push) begin
            st_nxt.wrPtr = st_r.wrPtr + 1'b1;
        end
        if (pop) begin
            st_nxt.rdPtr = st_r.rdPtr + 1'b1;
        end
        if (push && !pop) begin
            st_nxt.count = st_r.count + 1'b1;
        end else if (pop && !push) begin
            st_nxt.count = st_r.count - 1'b1;
        end
        // Full is kept in a flop so that the ready output leaves a register.
        st_nxt.full = (st_nxt.count == (AW+1)'(Depth));
    end

    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    always_ff @(posedge mclk) begin
        if (push) begin
            mem[st_r.wrPtr] <= inData;
        end
    end
endmodule

module iob_host (
    input wire logic mclk,
    input wire logic sys_rst,
    iob_bus_if.host bus,
    input wire logic reqValid,
    output logic reqReady,
    input wire iob_pkg::iob_cmd_t reqCmd,
    input wire logic [`IOB_DEV_W-1:0] reqDev,
    input wire logic [`IOB_DATA_W-1:0] reqData,
    output logic respValid,
    output logic [`IOB_DATA_W-1:0] respData,
    input wire logic instrCommitted,
    output logic grantValid,
    output logic [`IOB_CHAN_MSB:`IOB_CHAN_LSB] grantChan,
    input wire logic dismissValid,
    input wire logic [`IOB_CHAN_MSB:`IOB_CHAN_LSB] dismissChan
);
    typedef struct packed {
        iob_pkg::iob_host_state_t state;
        logic [`IOB_DEV_W-1:0] devNum;
        iob_pkg::iob_cmd_t cmd;
        logic strobe;
        logic [`IOB_DATA_W-1:0] data;
        logic dataOe_n;
        logic respValid;
        logic [`IOB_DATA_W-1:0] resp;
        logic [`IOB_CHANS:1] inService;
        logic grantValid;
        logic [`IOB_CHAN_MSB:`IOB_CHAN_LSB] grantChan;
    } iob_host_state_t;

    iob_host_state_t st_r;
    iob_host_state_t st_nxt;
    logic fifoValid;
    logic fifoReady;
    logic [`IOB_REQ_W-1:0] fifoData;
    logic [`IOB_CHANS:1] blocked;

    iob_fifo #(.Width(`IOB_REQ_W), .Depth(`IOB_FIFO_DEPTH)) u_iob_fifo (
        .mclk(mclk),
        .sys_rst(sys_rst),
        .inValid(reqValid),
        .inReady(reqReady),
        .inData({reqCmd, reqDev, reqData}),
        .outValid(fifoValid),
        .outReady(fifoReady),
        .outData(fifoData)
    );

    assign fifoReady = (st_r.state == iob_pkg::HS_IDLE);

    // A channel is blocked by itself or any lower-numbered active channel.
    genvar k;
    generate
        for (k = 1; k <= `IOB_CHANS; k++) begin : gBlk
            assign blocked[k] = |st_r.inService[k:1];
        end
    endgenerate

    always_comb begin
        logic found;
        found = 1'b0;
        st_nxt = st_r;
        st_nxt.strobe = 1'b0;
        st_nxt.dataOe_n = 1'b1;
        st_nxt.respValid = 1'b0;
        st_nxt.grantValid = 1'b0;
        case (st_r.state)
            iob_pkg::HS_IDLE: begin
                if (fifoValid) begin
                    st_nxt.cmd = iob_pkg::iob_cmd_t'(
                        fifoData[`IOB_REQ_W-1:`IOB_REQ_CMD_LSB]);
                    st_nxt.devNum =
                        fifoData[`IOB_REQ_CMD_LSB-1:`IOB_REQ_DEV_LSB];
                    st_nxt.data = fifoData[`IOB_DATA_W-1:0];
                    st_nxt.strobe = 1'b1;
                    st_nxt.dataOe_n =
                        !(st_nxt.cmd == iob_pkg::DATA_WRITE_CMD ||
                          st_nxt.cmd == iob_pkg::CONTROL_LOAD_CMD);
                    st_nxt.state = iob_pkg::HS_ISSUE;
                end
            end
            iob_pkg::HS_ISSUE: begin
                if (st_r.cmd == iob_pkg::CONDITION_READ_CMD ||
                    st_r.cmd == iob_pkg::DATA_READ_CMD) begin
                    st_nxt.state = iob_pkg::HS_WAIT;
                end else begin
                    st_nxt.state = iob_pkg::HS_IDLE;
                end
            end
            iob_pkg::HS_WAIT: begin
                st_nxt.resp = bus.busData;
                st_nxt.respValid = 1'b1;
                st_nxt.state = iob_pkg::HS_IDLE;
            end
            default: begin
                st_nxt.state = iob_pkg::HS_IDLE;
            end
        endcase
        if (dismissValid && dismissChan != '0) begin
            st_nxt.inService[dismissChan] = 1'b0;
        end
        if (!instrCommitted) begin
            for (int c = 1; c <= `IOB_CHANS; c++) begin
                if (!found && bus.irqReq[c] && !blocked[c]) begin
                    found = 1'b1;
                    st_nxt.inService[c] = 1'b1;
                    st_nxt.grantValid = 1'b1;
                    st_nxt.grantChan = (`IOB_CHAN_MSB+1)'(c);
                end
            end
        end
    end

    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            st_r.state <= iob_pkg::HS_IDLE;
            st_r.devNum <= '0;
            st_r.cmd <= iob_pkg::NO_CMD;
            st_r.strobe <= 1'b0;
            st_r.data <= '0;
            st_r.dataOe_n <= 1'b1;
            st_r.respValid <= 1'b0;
            st_r.resp <= '0;
            st_r.inService <= '0;
            st_r.grantValid <= 1'b0;
            st_r.grantChan <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign bus.devNum = st_r.devNum;
    assign bus.cmd = st_r.cmd;
    assign bus.cmdStrobe = st_r.strobe;
    assign bus.hostData = st_r.data;
    assign bus.hostDataOe_n = st_r.dataOe_n;
    assign bus.chanActive = st_r.inService;
    assign respValid = st_r.respValid;
    assign respData = st_r.resp;
    assign grantValid = st_r.grantValid;
    assign grantChan = st_r.grantChan;
endmodule
`default_nettype wire

// file: verification/iob_bus_chk.sv
`timescale 1ns/100ps
`default_nettype none
module iob_bus_chk #(
    parameter logic [6:0] DevNum = 7'h01
) (
    input wire logic mclk,
    input wire logic sys_rst,
    input wire logic [6:0] devNum,
    input wire iob_pkg::iob_cmd_t cmd,
    input wire logic cmdStrobe,
    input wire logic hostDataOe_n,
    input wire logic devDataOe_n,
    input wire logic [35:0] busData,
    input wire logic [7:1] irqReq,
    input wire logic [7:1] chanActive
);
    default clocking @(posedge mclk); endclocking
    default disable iff (sys_rst);
    logic mine, rdCmd, ldCmd;
    logic [7:1] prevAct_r, newAct;
    assign mine = cmdStrobe && devNum == DevNum;
    assign rdCmd = cmd == iob_pkg::CONDITION_READ_CMD ||
                   cmd == iob_pkg::DATA_READ_CMD;
    assign ldCmd = cmd == iob_pkg::CONTROL_LOAD_CMD;
    assign newAct = chanActive & ~prevAct_r;
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) prevAct_r <= 7'h0;
        else prevAct_r <= chanActive;
    end
    rd_answer_a: assert property (mine && rdCmd |=> !devDataOe_n)
        else $error("read not answered");
    drive_cause_a: assert property ($fell(devDataOe_n) |->
        $past(mine) && $past(rdCmd)) else $error("drive without select");
    other_dev_a: assert property (cmdStrobe && devNum != DevNum
        |=> devDataOe_n) else $error("answered other number");
    release_a: assert property (!devDataOe_n |=> devDataOe_n)
        else $error("lines held");
    host_drive_a: assert property (!hostDataOe_n |-> cmdStrobe &&
        (ldCmd || cmd == iob_pkg::DATA_WRITE_CMD)) else $error("host drive");
    irq_drop_a: assert property (|(irqReq & chanActive)
        |=> !(|(irqReq & chanActive))) else $error("request kept");
    unattach_a: assert property (mine && ldCmd &&
        busData[2:0] == 3'h0 |-> ##2 irqReq == 7'h0)
        else $error("channel zero requests");
    grant_order_a: assert property (newAct != 7'h0 |->
        $onehot(newAct) && (prevAct_r & (newAct - 7'h1)) == 7'h0 &&
        (newAct & $past(irqReq)) == newAct) else $error("grant order");
    cover property (mine && rdCmd);
    cover property (mine && ldCmd && busData[3]);
    cover property (newAct != 7'h0);
endmodule
`default_nettype wire

// file: verification/tb_io_bus_device_interface.sv
`timescale 1ns/100ps
`default_nettype none
module tb_io_bus_device_interface;
    logic mclk, sys_rst, reqValid, reqReady, respValid, instrCommitted;
    logic grantValid, dismissValid, userLoad;
    iob_pkg::iob_cmd_t reqCmd;
    logic [6:0] reqDev;
    logic [35:0] reqData, respData, userData, dataOut, v;
    logic [17:0] userStatus;
    logic [2:0] grantChan, dismissChan;
    logic [17:0] ctrlOut;
    logic ldPulse, wrPulse, rdPulse;
    logic [35:0] expQ[$];
    logic [31:0] seed = 32'ha03b8fd3;
    int failCount, totalChecks, i, ldCnt, wrCnt, rdCnt;
    iob_bus_if bus();
    iob_host u_iob_host (.mclk(mclk), .sys_rst(sys_rst), .bus(bus),
        .reqValid(reqValid), .reqReady(reqReady), .reqCmd(reqCmd),
        .reqDev(reqDev), .reqData(reqData), .respValid(respValid),
        .respData(respData), .instrCommitted(instrCommitted),
        .grantValid(grantValid), .grantChan(grantChan),
        .dismissValid(dismissValid), .dismissChan(dismissChan));
    iob_device u_iob_device (.mclk(mclk), .sys_rst(sys_rst), .bus(bus),
        .userStatus(userStatus), .userLoad(userLoad), .userData(userData),
        .ctrlOut(ctrlOut), .dataOut(dataOut), .ctrlLoadPulse(ldPulse),
        .dataWritePulse(wrPulse), .dataReadPulse(rdPulse));
    iob_bus_chk #(.DevNum(7'h01)) u_iob_bus_chk (.mclk(mclk),
        .sys_rst(sys_rst), .devNum(bus.devNum), .cmd(bus.cmd),
        .cmdStrobe(bus.cmdStrobe), .hostDataOe_n(bus.hostDataOe_n),
        .devDataOe_n(bus.devDataOe_n), .busData(bus.busData),
        .irqReq(bus.irqReq), .chanActive(bus.chanActive));
    initial begin
        mclk = 1'b0;
        forever #2.5 mclk = ~mclk;
    end
    function automatic logic [35:0] rnd();
        seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
        return {seed[7:4], seed};
    endfunction
    task automatic chk(input logic [35:0] e, input logic [35:0] a);
        totalChecks++;
        if (a !== e) begin
            failCount++;
            $display("ERROR t=%0t exp=%h got=%h", $time, e, a);
        end
    endtask
    task automatic req(input iob_pkg::iob_cmd_t c, input logic [6:0] d,
                       input logic [35:0] x);
        reqCmd = c;
        reqDev = d;
        reqData = x;
        reqValid = 1'b1;
        while (reqReady !== 1'b1) @(negedge mclk);
        @(negedge mclk);
    endtask
    task automatic rd(input iob_pkg::iob_cmd_t c, input logic [6:0] d,
                      input logic [35:0] e);
        expQ.push_back(e);
        req(c, d, e);
    endtask
    task automatic idle(input int n);
        reqValid = 1'b0;
        repeat (n) @(negedge mclk);
    endtask
    task automatic wrapUp();
        $display("checks %0d mismatches %0d", totalChecks, failCount);
        if (failCount == 0 && totalChecks > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    always @(negedge mclk)
        if (respValid === 1'b1)
            chk(expQ.size() > 0 ? expQ.pop_front() : 'x, respData);
    // Count the device's one-cycle pulses for the totals checked at the end.
    always @(negedge mclk) begin
        if (ldPulse === 1'b1) ldCnt++;
        if (wrPulse === 1'b1) wrCnt++;
        if (rdPulse === 1'b1) rdCnt++;
    end
    // The whole sequence needs about 250 cycles; this allows about twenty-four times that.
    initial begin
        #30000;
        failCount++;
        wrapUp();
    end
    initial begin
        {reqValid, instrCommitted, dismissValid, userLoad} = 4'b0100;
        reqCmd = iob_pkg::NO_CMD;
        reqDev = 7'h0;
        reqData = 36'h0;
        userData = 36'h0;
        userStatus = 18'h0;
        dismissChan = 3'h0;
        sys_rst = 1'b1;
        repeat (4) @(negedge mclk);
        sys_rst = 1'b0;
        v = rnd();
        req(iob_pkg::DATA_WRITE_CMD, 7'h01, v);
        rd(iob_pkg::DATA_READ_CMD, 7'h01, v);
        rd(iob_pkg::DATA_READ_CMD, 7'h05, 36'h0);
        req(iob_pkg::DATA_WRITE_CMD, 7'h05, ~v);
        req(iob_pkg::NO_CMD, 7'h01, ~v);
        rd(iob_pkg::DATA_READ_CMD, 7'h01, v);
        // Let the queued commands drain before the data register is reloaded.
        idle(20);
        v = rnd();
        userData = v;
        userLoad = 1'b1;
        @(negedge mclk);
        userLoad = 1'b0;
        rd(iob_pkg::DATA_READ_CMD, 7'h01, v);
        idle(20);
        $display("test data done");
        v = rnd();
        userStatus = v[17:0];
        req(iob_pkg::CONTROL_LOAD_CMD, 7'h01, 36'hf000a5a8);
        rd(iob_pkg::CONDITION_READ_CMD, 7'h01, {v[17:0], 18'h0a5a8});
        req(iob_pkg::CONTROL_LOAD_CMD, 7'h01, 36'h00000000b);
        rd(iob_pkg::CONDITION_READ_CMD, 7'h01, {v[17:0], 18'h0000b});
        idle(10);
        chk(36'h4, {29'h0, bus.irqReq});
        chk(36'h0000b, {18'h0, ctrlOut});
        instrCommitted = 1'b0;
        i = 0;
        while (grantValid !== 1'b1 && i < 10) begin
            @(negedge mclk);
            i++;
        end
        chk(36'h3, {33'h0, grantChan});
        instrCommitted = 1'b1;
        repeat (3) @(negedge mclk);
        chk(36'h0, {29'h0, bus.irqReq});
        dismissChan = 3'h3;
        dismissValid = 1'b1;
        @(negedge mclk);
        dismissValid = 1'b0;
        repeat (3) @(negedge mclk);
        chk(36'h4, {29'h0, bus.irqReq});
        req(iob_pkg::CONTROL_LOAD_CMD, 7'h01, 36'h0);
        idle(10);
        chk(36'h0, {29'h0, bus.irqReq});
        $display("test interrupt done");
        i = 0;
        while (reqReady === 1'b1 && i < 100) begin
            v = rnd();
            req(iob_pkg::DATA_WRITE_CMD, 7'h01, v);
            i++;
        end
        chk(36'h0, {35'h0, reqReady});
        rd(iob_pkg::DATA_READ_CMD, 7'h01, v);
        // A full queue of writes takes two cycles each to reach the bus.
        idle(90);
        chk(v, dataOut);
        chk(36'h1, {35'h0, reqReady});
        chk(36'h0, 36'(expQ.size()));
        chk(36'h3, 36'(ldCnt));
        chk(36'(i + 1), 36'(wrCnt));
        chk(36'h4, 36'(rdCnt));
        $display("test buffer done");
        wrapUp();
    end
endmodule
`default_nettype wire
